// [design/capture_sequencer.sv]
// Purpose: State-based trigger sequencer driving the write side of an acquisition buffer.
// Assumes: All inputs synchronous to ref_clk; program and configuration static during a run.
// Notes:   Conditions are evaluated on the current cycle; actions land at the next edge.
// Functional notes
// - First true branch wins, else default.
// - Conditions nest negation and conjunction: two negatable AND groups under an outer NOT.
// - Six relational compares on counters or flags.
// - All actions of a branch apply together.
// - Increment adds exactly one.
// - Decrement subtracts exactly one.
// - Counter reset reloads its initial value.
// - Set drives flag one, clear zero.
// - Trigger ends acquisition, optional post count.
// - Segment close advances segment, wraps oldest.
// - Segmented trigger stops acquisition at once.
// - Capture-on asserts the buffer write strobe.
// - Capture-off deasserts the buffer write strobe.
// - Goto loads the target as next state.
// - Capture actions only for non-segmented buffer.
// - Qualified non-segmented mode writes nothing before capture-on.
// - Keep writing until post count satisfied.
// - Post count done first completes acquisition.
// - Early capture-off pauses until capture-on returns.
// - Capture actions still evaluated after trigger.
// - Counters, flags, state observable while running.
// - Up to twenty states, count configurable.
// - Twenty counters and flags, init and width.
// - External trigger must hold before flow starts.
`timescale 1ns/10ps
module capture_sequencer (
  input  wire logic                                 ref_clk,
  input  wire logic                                 reset_n,
  input  wire logic                                 start_analysis,
  input  wire logic                                 manual_stop,
  input  wire logic                                 ext_trig_in,
  input  wire logic [seq_pkg::N_TRIG-1:0]           trig_cond,
  input  wire logic [seq_pkg::SMP_W-1:0]            sample_in,
  input  wire seq_pkg::cfg_s                        cfg,
  input  wire seq_pkg::prog_t                       prog,
  output logic                                      buf_wr_en,
  output logic [seq_pkg::SMP_W-1:0]                 buf_data,
  output logic                                      seg_advance,
  output logic [seq_pkg::SEG_W-1:0]                 seg_index,
  output seq_pkg::phase_e                           acq_phase,
  output logic                                      acq_done,
  output logic                                      triggered,
  output logic                                      store_active,
  output logic [seq_pkg::ST_W-1:0]                  cur_state,
  output seq_pkg::cnt_arr_t                         cnt_value,
  output logic [seq_pkg::N_FLAG-1:0]                flag_value,
  output logic [seq_pkg::CNT_W-1:0]                 post_left
);

  seq_pkg::core_s                      core_reg;
  seq_pkg::core_s                      core_next;
  seq_pkg::act_s                       act;
  logic [seq_pkg::LIT_W-1:0]           lit;
  logic [seq_pkg::N_CMP-1:0]           cmp_hit;
  logic                                running;
  logic                                store_ok;

  // Width 0 or anything at or above the full width means the full counter.
  function automatic logic [seq_pkg::CNT_W-1:0] wmask(input logic [seq_pkg::WID_W-1:0] w);
    logic [seq_pkg::CNT_W-1:0] m;
    m = seq_pkg::CNT_ONES;
    if (w != seq_pkg::WID_NONE && w < seq_pkg::WID_FULL) begin
      m = ~(seq_pkg::CNT_ONES << w);
    end
    return m;
  endfunction : wmask

  function automatic logic relate(input seq_pkg::cmp_op_e op,
                                  input logic [seq_pkg::CNT_W-1:0] a,
                                  input logic [seq_pkg::CNT_W-1:0] b);
    logic h;
    h = 1'b0;
    case (op)
      seq_pkg::OP_GT: h = a > b;
      seq_pkg::OP_GE: h = a >= b;
      seq_pkg::OP_EQ: h = a == b;
      seq_pkg::OP_NE: h = a != b;
      seq_pkg::OP_LE: h = a <= b;
      seq_pkg::OP_LT: h = a < b;
      default: h = 1'b0;
    endcase
    return h;
  endfunction : relate

  // Each group is an AND of selected, optionally inverted literals; a group may itself be
  // negated and the AND of the groups may be negated again, giving nested NOT/AND terms.
  function automatic logic eval_cond(input seq_pkg::cond_s c, input logic [seq_pkg::LIT_W-1:0] l);
    logic all;
    logic g;
    all = 1'b1;
    for (int k = 0; k < seq_pkg::N_GRP; k++) begin
      g = &(~c.mask[k] | (l ^ c.inv[k]));
      all = all & (g ^ c.neg[k]);
    end
    return all ^ c.out_neg;
  endfunction : eval_cond

  // Branch actions extend the unconditional ones; a branch goto or count overrides.
  function automatic seq_pkg::act_s act_merge(input seq_pkg::act_s a, input seq_pkg::act_s b);
    seq_pkg::act_s m;
    m = a | b;
    m.go_state = b.go ? b.go_state : a.go_state;
    m.use_post = b.trig ? b.use_post : a.use_post;
    m.post     = b.trig ? b.post : a.post;
    return m;
  endfunction : act_merge

  always_comb begin
    for (int i = 0; i < seq_pkg::N_CMP; i++) begin
      cmp_hit[i] = 1'b0;
      // A flag operand is zero extended, so it compares as 0 or 1.
      if (cfg.cmp[i].is_flag && cfg.cmp[i].sel < seq_pkg::SEL_W'(seq_pkg::N_FLAG)) begin
        cmp_hit[i] = relate(cfg.cmp[i].op, {{(seq_pkg::CNT_W-1){1'b0}}, core_reg.flags[cfg.cmp[i].sel]},
                            cfg.cmp[i].value);
      end else if (!cfg.cmp[i].is_flag && cfg.cmp[i].sel < seq_pkg::SEL_W'(seq_pkg::N_CNT)) begin
        cmp_hit[i] = relate(cfg.cmp[i].op, core_reg.cnt[cfg.cmp[i].sel], cfg.cmp[i].value);
      end
    end
  end

  assign lit      = {cmp_hit, core_reg.flags, trig_cond};
  assign running  = core_reg.phase == seq_pkg::PH_RUN || core_reg.phase == seq_pkg::PH_POST;
  // Outside qualified non-segmented mode every running cycle stores a sample, except a segmented trigger cycle and the POST cycle that completes.
  assign store_ok = !cfg.qual_en || cfg.segmented || core_reg.store_on;

  always_comb begin
    logic found;
    seq_pkg::state_prog_s sp;
    found = 1'b0;
    sp = prog[core_reg.cur];
    act = sp.dflt;
    for (int b = 0; b < seq_pkg::N_BR; b++) begin
      if (!found && sp.br_en[b] && eval_cond(sp.br_cond[b], lit)) begin
        found = 1'b1;
        act = sp.br_act[b];
      end
    end
    act = act_merge(sp.uncond, act);
  end

  always_comb begin
    core_next = core_reg;
    core_next.wr_en = 1'b0;
    core_next.seg_adv = 1'b0;
    if (start_analysis) begin
      core_next.phase     = seq_pkg::PH_ARM;
      core_next.cur       = seq_pkg::ST_FIRST;
      // Initial values honour the counter width, as a reset action does.
      for (int i = 0; i < seq_pkg::N_CNT; i++) begin
        core_next.cnt[i] = cfg.cnt_init[i] & wmask(cfg.cnt_width[i]);
      end
      core_next.flags     = cfg.flag_init;
      core_next.store_on  = 1'b0;
      core_next.triggered = 1'b0;
      core_next.post_left = seq_pkg::CNT_ZERO;
      core_next.seg_idx   = seq_pkg::SEG_FIRST;
    // A stop in IDLE is dropped: nothing is armed that could complete.
    end else if (manual_stop && core_reg.phase != seq_pkg::PH_IDLE) begin
      core_next.phase     = seq_pkg::PH_DONE;
      core_next.triggered = 1'b1;
    end else begin
      case (core_reg.phase)
        seq_pkg::PH_ARM: begin
          if (!cfg.ext_trig_en || ext_trig_in) begin
            core_next.phase = seq_pkg::PH_RUN;
          end
        end
        seq_pkg::PH_RUN, seq_pkg::PH_POST: begin
          // Reset beats inc and dec; inc with dec leaves the count alone.
          for (int i = 0; i < seq_pkg::N_CNT; i++) begin
            if (act.rst[i]) begin
              core_next.cnt[i] = cfg.cnt_init[i] & wmask(cfg.cnt_width[i]);
            end else if (act.inc[i] && !act.dec[i]) begin
              core_next.cnt[i] = (core_reg.cnt[i] + seq_pkg::CNT_STEP) & wmask(cfg.cnt_width[i]);
            end else if (act.dec[i] && !act.inc[i]) begin
              core_next.cnt[i] = (core_reg.cnt[i] - seq_pkg::CNT_STEP) & wmask(cfg.cnt_width[i]);
            end
          end
          // Set wins when one state both sets and clears the same flag.
          core_next.flags = (core_reg.flags & ~act.clr) | act.set;
          // Targets past either state limit are dropped; the program is never indexed out of range.
          if (act.go && act.go_state < cfg.num_states && act.go_state < seq_pkg::ST_W'(seq_pkg::N_STATE)) begin
            core_next.cur = act.go_state;
          end
          if (cfg.qual_en && !cfg.segmented) begin
            if (act.store_on) begin
              core_next.store_on = 1'b1;
            end else if (act.store_off) begin
              core_next.store_on = 1'b0;
            end
          end
          if (store_ok) begin
            core_next.wr_en  = 1'b1;
            core_next.sample = sample_in;
          end
          // Wrapping to segment 0 overwrites the oldest one.
          if (cfg.segmented && act.seg_close) begin
            core_next.seg_adv = 1'b1;
            core_next.seg_idx = (core_reg.seg_idx + seq_pkg::SEG_STEP >= cfg.num_seg) ?
                                seq_pkg::SEG_FIRST : core_reg.seg_idx + seq_pkg::SEG_STEP;
          end
          // Only the first trigger counts; in POST a repeated one is ignored.
          if (core_reg.phase == seq_pkg::PH_RUN && act.trig) begin
            core_next.triggered = 1'b1;
            if (cfg.segmented) begin
              core_next.phase = seq_pkg::PH_DONE;
              core_next.wr_en = 1'b0;
            end else begin
              core_next.phase     = seq_pkg::PH_POST;
              core_next.post_left = act.use_post ? act.post : cfg.default_post;
            end
          end else if (core_reg.phase == seq_pkg::PH_POST) begin
            if (core_reg.post_left == seq_pkg::CNT_ZERO) begin
              core_next.phase = seq_pkg::PH_DONE;
              core_next.wr_en = 1'b0;
            // The trigger sample is not counted, and a paused cycle neither writes nor counts.
            end else if (store_ok) begin
              core_next.post_left = core_reg.post_left - seq_pkg::CNT_STEP;
            end
          end
        end
        seq_pkg::PH_IDLE, seq_pkg::PH_DONE: begin
          core_next.phase = core_reg.phase;
        end
        default: begin
          core_next.phase = seq_pkg::PH_IDLE;
        end
      endcase
    end
    // The done level has its own flop so that acq_done is a register output.
    core_next.done = core_next.phase == seq_pkg::PH_DONE;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      core_reg <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  assign buf_wr_en    = core_reg.wr_en;
  assign buf_data     = core_reg.sample;
  assign seg_advance  = core_reg.seg_adv;
  assign seg_index    = core_reg.seg_idx;
  assign acq_phase    = core_reg.phase;
  assign acq_done     = core_reg.done;
  assign triggered    = core_reg.triggered;
  assign store_active = core_reg.store_on;
  assign cur_state    = core_reg.cur;
  assign cnt_value    = core_reg.cnt;
  assign flag_value   = core_reg.flags;
  assign post_left    = core_reg.post_left;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic quiet;
  assign quiet = !start_analysis && !manual_stop;

  sequence post_empty_s;
    quiet && core_reg.phase == seq_pkg::PH_POST && core_reg.post_left == seq_pkg::CNT_ZERO;
  endsequence
  sequence done_hold_s;
    acq_done && !buf_wr_en;
  endsequence

  // Apart from start_load_a and manual_stop_a, checks stay quiet around start and stop pulses, which override every action.
  start_load_a: assert property (start_analysis |=> cur_state == seq_pkg::ST_FIRST && !triggered
                                 && !store_active && acq_phase == seq_pkg::PH_ARM)
    else $error("start did not load the first state");
  qual_gate_a: assert property (quiet && running && cfg.qual_en && !cfg.segmented && !store_active
                                |=> !buf_wr_en)
    else $error("sample written while capture is off");
  run_write_a: assert property (quiet && acq_phase == seq_pkg::PH_RUN && store_ok && !act.trig
                                |=> buf_wr_en && buf_data == $past(sample_in))
    else $error("stored sample not written");

  inc_step_a: assert property (quiet && running && act.inc[0] && !act.dec[0] && !act.rst[0]
                               |=> cnt_value[0] == ((($past(cnt_value[0]) + seq_pkg::CNT_STEP))
                                   & wmask(cfg.cnt_width[0])))
    else $error("increment did not add one");
  dec_step_a: assert property (quiet && running && act.dec[0] && !act.inc[0] && !act.rst[0]
                               |=> cnt_value[0] == ((($past(cnt_value[0]) - seq_pkg::CNT_STEP))
                                   & wmask(cfg.cnt_width[0])))
    else $error("decrement did not subtract one");
  cnt_reload_a: assert property (quiet && running && act.rst[0]
                                 |=> cnt_value[0] == (cfg.cnt_init[0] & wmask(cfg.cnt_width[0])))
    else $error("counter reset did not reload");
  flag_set_a: assert property (quiet && running && act.set[0] |=> flag_value[0])
    else $error("flag set failed");
  flag_clr_a: assert property (quiet && running && act.clr[1] && !act.set[1] |=> !flag_value[1])
    else $error("flag clear failed");

  goto_load_a: assert property (quiet && running && act.go && act.go_state < cfg.num_states
                                && act.go_state < seq_pkg::ST_W'(seq_pkg::N_STATE)
                                |=> cur_state == $past(act.go_state))
    else $error("goto target not loaded");
  arm_wait_a: assert property (quiet && acq_phase == seq_pkg::PH_ARM && cfg.ext_trig_en && !ext_trig_in
                               |=> acq_phase == seq_pkg::PH_ARM)
    else $error("flow started without external trigger");

  trig_post_a: assert property (quiet && acq_phase == seq_pkg::PH_RUN && act.trig && !cfg.segmented
                                |=> acq_phase == seq_pkg::PH_POST && triggered)
    else $error("trigger did not enter post fill");
  seg_stop_a: assert property (quiet && acq_phase == seq_pkg::PH_RUN && act.trig && cfg.segmented
                               |=> done_hold_s)
    else $error("segmented trigger did not stop");
  trig_hold_a: assert property (quiet && triggered |=> triggered)
    else $error("trigger indication dropped");
  post_count_a: assert property (quiet && acq_phase == seq_pkg::PH_POST && store_ok
                                 && post_left != seq_pkg::CNT_ZERO
                                 |=> post_left == $past(post_left) - seq_pkg::CNT_STEP)
    else $error("post fill count did not step");

  post_done_a: assert property (post_empty_s |=> done_hold_s)
    else $error("post fill did not complete");
  done_hold_a: assert property (quiet && acq_done |=> done_hold_s)
    else $error("done did not hold");
  manual_stop_a: assert property (manual_stop && !start_analysis && acq_phase != seq_pkg::PH_IDLE
                                  |=> acq_done && triggered)
    else $error("manual stop did not force completion");

  store_on_a: assert property (quiet && running && cfg.qual_en && !cfg.segmented && act.store_on
                               |=> store_active)
    else $error("capture-on not taken");
  store_off_a: assert property (quiet && running && cfg.qual_en && !cfg.segmented && act.store_off
                                && !act.store_on |=> !store_active)
    else $error("capture-off not taken");

  seg_qual_a: assert property (quiet && running && cfg.segmented && !store_active |=> !store_active)
    else $error("capture action taken in segmented mode");
  seg_adv_a: assert property (quiet && running && cfg.segmented && act.seg_close |=> seg_advance)
    else $error("segment close not taken");

endmodule : capture_sequencer

// [design/seq_pkg.sv]
// Purpose: Shared constants, types and program layout of the capture sequencer.
// Assumes: One sampling clock; the program and configuration are held stable while running.
// Notes:   Literal vector order is {compare hits, flags, trigger conditions}.
package seq_pkg;
  localparam int N_STATE = 20;
  localparam int N_CNT   = 20;
  localparam int N_FLAG  = 20;
  localparam int N_TRIG  = 8;
  localparam int N_CMP   = 4;
  localparam int N_BR    = 3;
  localparam int N_GRP   = 2;
  localparam int CNT_W   = 16;
  localparam int SMP_W   = 32;
  localparam int ST_W    = 5;
  localparam int SEL_W   = 5;
  localparam int SEG_W   = 4;
  localparam int WID_W   = 5;
  localparam int LIT_W   = N_TRIG + N_FLAG + N_CMP;

  localparam logic [CNT_W-1:0] CNT_STEP  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ONES  = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [ST_W-1:0]  ST_FIRST  = 5'h00;
  localparam logic [SEG_W-1:0] SEG_FIRST = 4'h0;
  localparam logic [SEG_W-1:0] SEG_STEP  = 4'h1;
  localparam logic [WID_W-1:0] WID_FULL  = 5'h10;
  localparam logic [WID_W-1:0] WID_NONE  = 5'h00;

  typedef enum logic [2:0] {OP_GT, OP_GE, OP_EQ, OP_NE, OP_LE, OP_LT} cmp_op_e;
  typedef enum logic [2:0] {PH_IDLE, PH_ARM, PH_RUN, PH_POST, PH_DONE} phase_e;

  typedef logic [N_CNT-1:0][CNT_W-1:0] cnt_arr_t;

  typedef struct packed {
    logic             is_flag;
    logic [SEL_W-1:0] sel;
    cmp_op_e          op;
    logic [CNT_W-1:0] value;
  } cmp_cfg_s;

  typedef struct packed {
    logic [N_GRP-1:0][LIT_W-1:0] mask;
    logic [N_GRP-1:0][LIT_W-1:0] inv;
    logic [N_GRP-1:0]            neg;
    logic                        out_neg;
  } cond_s;

  typedef struct packed {
    logic [N_CNT-1:0]  inc;
    logic [N_CNT-1:0]  dec;
    logic [N_CNT-1:0]  rst;
    logic [N_FLAG-1:0] set;
    logic [N_FLAG-1:0] clr;
    logic              go;
    logic [ST_W-1:0]   go_state;
    logic              trig;
    logic              use_post;
    logic [CNT_W-1:0]  post;
    logic              seg_close;
    logic              store_on;
    logic              store_off;
  } act_s;

  typedef struct packed {
    act_s                  uncond;
    logic [N_BR-1:0]       br_en;
    cond_s [N_BR-1:0]      br_cond;
    act_s  [N_BR-1:0]      br_act;
    act_s                  dflt;
  } state_prog_s;

  typedef state_prog_s [N_STATE-1:0] prog_t;

  typedef struct packed {
    logic [ST_W-1:0]               num_states;
    cnt_arr_t                      cnt_init;
    logic [N_CNT-1:0][WID_W-1:0]   cnt_width;
    logic [N_FLAG-1:0]             flag_init;
    cmp_cfg_s [N_CMP-1:0]          cmp;
    logic                          qual_en;
    logic                          segmented;
    logic [SEG_W-1:0]              num_seg;
    logic [CNT_W-1:0]              default_post;
    logic                          ext_trig_en;
  } cfg_s;

  typedef struct packed {
    phase_e            phase;
    logic [ST_W-1:0]   cur;
    cnt_arr_t          cnt;
    logic [N_FLAG-1:0] flags;
    logic              store_on;
    logic              triggered;
    logic [CNT_W-1:0]  post_left;
    logic [SEG_W-1:0]  seg_idx;
    logic              wr_en;
    logic [SMP_W-1:0]  sample;
    logic              seg_adv;
    logic              done;
  } core_s;
endpackage : seq_pkg

// [dv/testbench.sv]
// Purpose: Self-checking bench for the capture sequencer.
// Assumes: Inputs change 1 ns after the rising edge; outputs are sampled at that same point.
// Notes:   Program and config are changed only around a fresh start, never mid-run.
`timescale 1ns/10ps
module testbench;
  logic                       ref_clk;
  logic                       reset_n;
  logic                       start_analysis;
  logic                       manual_stop;
  logic                       ext_trig_in;
  logic [seq_pkg::N_TRIG-1:0] trig_cond;
  logic [seq_pkg::SMP_W-1:0]  sample_in;
  seq_pkg::cfg_s              cfg;
  seq_pkg::prog_t             prog;
  logic                       buf_wr_en;
  logic [seq_pkg::SMP_W-1:0]  buf_data;
  logic                       seg_advance;
  logic [seq_pkg::SEG_W-1:0]  seg_index;
  seq_pkg::phase_e            acq_phase;
  logic                       acq_done;
  logic                       triggered;
  logic                       store_active;
  logic [seq_pkg::ST_W-1:0]   cur_state;
  seq_pkg::cnt_arr_t          cnt_value;
  logic [seq_pkg::N_FLAG-1:0] flag_value;
  logic [seq_pkg::CNT_W-1:0]  post_left;
  int                         bad_count;
  int                         n_checks;
  int                         i;
  int                         v;

  capture_sequencer capture_sequencer_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .start_analysis(start_analysis), .manual_stop(manual_stop),
    .ext_trig_in(ext_trig_in), .trig_cond(trig_cond), .sample_in(sample_in), .cfg(cfg), .prog(prog),
    .buf_wr_en(buf_wr_en), .buf_data(buf_data), .seg_advance(seg_advance), .seg_index(seg_index),
    .acq_phase(acq_phase), .acq_done(acq_done), .triggered(triggered), .store_active(store_active),
    .cur_state(cur_state), .cnt_value(cnt_value), .flag_value(flag_value), .post_left(post_left)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bounded wait, so a design stuck in one phase ends the run instead of hanging it.
  task automatic wait_ph(input seq_pkg::phase_e ph);
    int k;
    for (k = 0; k < 20 && acq_phase !== ph; k++) tick();
    if (acq_phase !== ph) begin
      bad_count++;
      $display("[ERR] phase wait expected %0d seen %0d", ph, acq_phase);
      close_out();
    end
  endtask : wait_ph

  task automatic stepd(input logic [7:0] t, input logic [31:0] d);
    trig_cond = t;
    sample_in = d;
    tick();
  endtask : stepd

  task automatic start_run();
    trig_cond      = '0;
    start_analysis = 1'b1;
    tick();
    start_analysis = 1'b0;
    chk("phase", 32'(seq_pkg::PH_ARM), 32'(acq_phase));
    chk("state", 32'h0000_0000, 32'(cur_state));
    chk("cnt0", 32'(cfg.cnt_init[0]), 32'(cnt_value[0]));
    chk("flags", 32'(cfg.flag_init), 32'(flag_value));
    chk("trig", 32'h0000_0000, 32'(triggered));
  endtask : start_run

  function automatic logic exp_hit(input int op, input int a, input int b);
    case (op)
      0:       return a > b;
      1:       return a >= b;
      2:       return a == b;
      3:       return a != b;
      4:       return a <= b;
      default: return a < b;
    endcase
  endfunction : exp_hit

  initial begin
    reset_n = 1'b0;
    start_analysis = 1'b0;
    manual_stop = 1'b0;
    ext_trig_in = 1'b0;
    trig_cond = '0;
    sample_in = '0;
    cfg = '0;
    prog = '0;
    bad_count = 0;
    n_checks = 0;
    cfg.num_states = 5'h02;
    cfg.cnt_init[0] = 16'h0005;
    cfg.cnt_init[1] = 16'h0003;
    cfg.cnt_init[2] = 16'h0100;
    cfg.flag_init = 20'h0_0008;
    cfg.qual_en = 1'b1;
    cfg.num_seg = 4'h2;
    cfg.default_post = 16'h0003;
    prog[0].uncond.inc[2] = 1'b1;
    prog[0].br_en = 3'h7;
    prog[0].br_cond[0].mask[0] = 32'h0000_0001;
    prog[0].br_act[0].inc[0] = 1'b1;
    prog[0].br_act[0].set[1] = 1'b1;
    prog[0].br_act[0].seg_close = 1'b1;
    prog[0].br_cond[1].mask[0] = 32'h0000_0002;
    prog[0].br_act[1].dec[1] = 1'b1;
    prog[0].br_act[1].clr[1] = 1'b1;
    prog[0].br_act[1].rst[0] = 1'b1;
    prog[0].br_cond[2].mask[0] = 32'h0000_0004;
    prog[0].br_cond[2].mask[1] = 32'h0000_0008;
    prog[0].br_cond[2].neg[1] = 1'b1;
    prog[0].br_act[2].go = 1'b1;
    prog[0].br_act[2].go_state = 5'h01;
    prog[0].dflt.set[0] = 1'b1;
    prog[1].br_en = 3'h7;
    prog[1].br_cond[0].mask[0] = 32'h0000_0010;
    prog[1].br_act[0].store_on = 1'b1;
    prog[1].br_cond[1].mask[0] = 32'h0000_0020;
    prog[1].br_act[1].store_off = 1'b1;
    prog[1].br_cond[2].mask[0] = 32'h0000_0040;
    prog[1].br_act[2].trig = 1'b1;
    prog[1].br_act[2].use_post = 1'b1;
    prog[1].br_act[2].post = 16'h0002;
    tick();
    tick();
    reset_n = 1'b1;
    manual_stop = 1'b1;
    tick();
    manual_stop = 1'b0;
    chk("idle stop", 32'(seq_pkg::PH_IDLE), 32'(acq_phase));
    $display("test reset done");
    start_run();
    wait_ph(seq_pkg::PH_RUN);
    stepd(8'h03, 32'h0000_0000);
    chk("cnt0", 32'h0000_0006, 32'(cnt_value[0]));
    chk("cnt2", 32'h0000_0101, 32'(cnt_value[2]));
    chk("flags", 32'h0000_000a, 32'(flag_value));
    chk("seg adv", 32'h0000_0000, 32'(seg_advance));
    stepd(8'h02, 32'h0000_0000);
    chk("cnt0", 32'h0000_0005, 32'(cnt_value[0]));
    chk("cnt1", 32'h0000_0002, 32'(cnt_value[1]));
    chk("flags", 32'h0000_0008, 32'(flag_value));
    stepd(8'h00, 32'h0000_0000);
    chk("flags", 32'h0000_0009, 32'(flag_value));
    stepd(8'h0c, 32'h0000_0000);
    chk("state", 32'h0000_0000, 32'(cur_state));
    chk("cnt2", 32'h0000_0104, 32'(cnt_value[2]));
    stepd(8'h04, 32'h0000_0000);
    chk("state", 32'h0000_0001, 32'(cur_state));
    chk("wr", 32'h0000_0000, 32'(buf_wr_en));
    $display("test flow done");
    stepd(8'h10, 32'h0000_0001);
    chk("store", 32'h0000_0001, 32'(store_active));
    chk("wr", 32'h0000_0000, 32'(buf_wr_en));
    stepd(8'h00, 32'h0000_0002);
    chk("wr", 32'h0000_0001, 32'(buf_wr_en));
    chk("data", 32'h0000_0002, buf_data);
    stepd(8'h40, 32'h0000_0003);
    chk("phase", 32'(seq_pkg::PH_POST), 32'(acq_phase));
    chk("left", 32'h0000_0002, 32'(post_left));
    chk("trig", 32'h0000_0001, 32'(triggered));
    stepd(8'h20, 32'h0000_0004);
    chk("data", 32'h0000_0004, buf_data);
    chk("left", 32'h0000_0001, 32'(post_left));
    chk("store", 32'h0000_0000, 32'(store_active));
    stepd(8'h00, 32'h0000_0005);
    chk("wr", 32'h0000_0000, 32'(buf_wr_en));
    chk("phase", 32'(seq_pkg::PH_POST), 32'(acq_phase));
    stepd(8'h10, 32'h0000_0006);
    stepd(8'h00, 32'h0000_0007);
    chk("data", 32'h0000_0007, buf_data);
    chk("left", 32'h0000_0000, 32'(post_left));
    stepd(8'h00, 32'h0000_0008);
    chk("done", 32'h0000_0001, 32'(acq_done));
    chk("wr", 32'h0000_0000, 32'(buf_wr_en));
    $display("test storage done");
    start_run();
    wait_ph(seq_pkg::PH_RUN);
    stepd(8'h04, 32'h0000_0000);
    stepd(8'h40, 32'h0000_0000);
    for (i = 0; i < 4; i++) stepd(8'h00, 32'h0000_0000);
    chk("paused", 32'(seq_pkg::PH_POST), 32'(acq_phase));
    manual_stop = 1'b1;
    tick();
    manual_stop = 1'b0;
    chk("stop", 32'h0000_0001, 32'(acq_done));
    $display("test stop done");
    cfg.segmented = 1'b1;
    cfg.qual_en = 1'b0;
    cfg.ext_trig_en = 1'b1;
    start_run();
    for (i = 0; i < 3; i++) tick();
    chk("ext wait", 32'(seq_pkg::PH_ARM), 32'(acq_phase));
    ext_trig_in = 1'b1;
    wait_ph(seq_pkg::PH_RUN);
    stepd(8'h01, 32'h0000_0011);
    chk("seg adv", 32'h0000_0001, 32'(seg_advance));
    chk("seg idx", 32'h0000_0001, 32'(seg_index));
    chk("wr", 32'h0000_0001, 32'(buf_wr_en));
    stepd(8'h01, 32'h0000_0012);
    chk("seg idx", 32'h0000_0000, 32'(seg_index));
    stepd(8'h04, 32'h0000_0013);
    chk("seg adv", 32'h0000_0000, 32'(seg_advance));
    stepd(8'h10, 32'h0000_0014);
    chk("store", 32'h0000_0000, 32'(store_active));
    stepd(8'h40, 32'h0000_0015);
    chk("seg trig", 32'(seq_pkg::PH_DONE), 32'(acq_phase));
    $display("test segment done");
    cfg.segmented = 1'b0;
    cfg.qual_en = 1'b1;
    cfg.ext_trig_en = 1'b0;
    ext_trig_in = 1'b0;
    prog[0].br_cond[0].mask[0] = 32'h1000_0000;
    for (i = 0; i < 6; i++) begin
      for (v = 4; v < 7; v++) begin
        cfg.cmp[0].op = seq_pkg::cmp_op_e'(i);
        cfg.cmp[0].value = 16'(v);
        start_run();
        wait_ph(seq_pkg::PH_RUN);
        stepd(8'h00, 32'h0000_0000);
        chk("cmp", 32'(exp_hit(i, 5, v)), 32'(flag_value[1]));
      end
    end
    cfg.cmp[0] = '{1'b1, 5'h03, seq_pkg::OP_EQ, 16'h0001};
    start_run();
    wait_ph(seq_pkg::PH_RUN);
    stepd(8'h00, 32'h0000_0000);
    chk("flag cmp", 32'h0000_0001, 32'(flag_value[1]));
    $display("test compare done");
    close_out();
  end
endmodule : testbench
